// file: core/uadc_pkg.sv
/*
 * Package for the USB attach and detach control block: register offsets,
 * field positions, reset values, states and the control register layout.
 * Assumes one 25 MHz clock and a plain strobe-based register port.
 */
package uadc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PINSEL = 8'h04;
  localparam logic [7:0] OFF_POWER = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // ****************************************************************
  // General pins and selector fields
  // ****************************************************************
  localparam int unsigned GP_NUM = 16;
  localparam int unsigned PIN_W = 4;
  localparam int unsigned POS_SENSE = 0;
  localparam int unsigned POS_DETACH = 4;
  localparam int unsigned POS_WAKE = 8;
  localparam int unsigned POS_PULL = 12;
  localparam logic [PIN_W-1:0] RST_SENSE_PIN = 4'h0;
  localparam logic [PIN_W-1:0] RST_DETACH_PIN = 4'h1;
  localparam logic [PIN_W-1:0] RST_WAKE_PIN = 4'h2;
  localparam logic [PIN_W-1:0] RST_PULL_PIN = 4'h3;

  // ****************************************************************
  // Power descriptor: units of 2 mA, so 100 mA is 50
  // ****************************************************************
  localparam int unsigned PWR_W = 8;
  localparam logic [PWR_W-1:0] RST_POWER = 8'h32;

  // Bus signalling rate in bit/s; full speed only
  localparam int unsigned FS_RATE = 12000000;

  // Control register, bit 6 downward
  typedef struct packed {
    logic wake_req;      // [6] ask the host to resume
    logic aux_allow;     // [5] external LEDs and amplifiers
    logic radio_allow;   // [4] radio operation
    logic endpoint_set;  // [3] 0 wireless transport, 1 audio class
    logic bus_powered;   // [2] power drawn from the cable
    logic pullup_source_select; // [1] 0 internal, 1 general pin
    logic ready;         // [0] firmware ready to enumerate
  } uadc_ctrl_s;

  localparam int unsigned CTRL_W = 7;
  localparam logic [CTRL_W-1:0] RST_CTRL = 7'h34;

  // Connection states
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ATTACHED = 3'b010,
    ST_SUSPENDED = 3'b100
  } uadc_state_e;

endpackage

// file: core/uadc_attach_ctrl.sv
/*
 * USB attach and detach control for a full-speed peripheral port.
 * Assumes inputs synchronous to clk_in, a serial engine that reports
 * bus suspend, and transceivers that obey the high impedance request.
 */
// Chosen here: the strobed register port and the register addresses.
// Notes on behaviour
// [R01] Full-speed 12 Mbit/s interface only
// [R02] Peripheral only, never initiates bus traffic
// [R03] Works with open and universal host controllers
// [R04] Endpoint set selectable: wireless or audio
// [R05] Internal pull-up only once ready to enumerate
// [R06] Pull-up source selectable, internal by default
// [R07] D+ never pulled while bus power absent
// [R08] Power sense taken from selectable general pin
// [R09] Default descriptor power request is 100 mA
// [R10] Descriptor power taken from a configuration setting
// [R11] Host may suspend; whole circuit can suspend
// [R12] Bus-powered suspend disables the radio
// [R13] LEDs and amplifiers switch off in suspend
// [R14] Detach high: lines floating, pull-up off
// [R15] Detach low: reattach and await enumeration
// [R16] Host-wake output, active high, only while detached
// [R17] No in-band remote wake while detached
// [R18] Detach and wake pins selectable by number
// [R19] High-speed hosts settle at full speed
// [R20] External pull-up pin follows internal pull-up
`timescale 1ns/1ps
module uadc_attach_ctrl
  import uadc_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic [GP_NUM-1:0] gp_in,
  output logic [GP_NUM-1:0] gp_out,
  output logic [GP_NUM-1:0] gp_oe_out,
  input wire logic bus_suspend_in,
  output logic dp_pullup_out,
  output logic usb_hiz_out,
  output logic full_speed_out,
  output logic inband_wake_out,
  output logic endpoint_set_out,
  output logic [PWR_W-1:0] desc_power_out,
  output logic radio_en_out,
  output logic aux_en_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  uadc_ctrl_s ctrl_reg;
  logic [15:0] pinsel_reg;
  logic [PWR_W-1:0] power_reg;
  logic [DATA_W-1:0] rdata_reg;
  uadc_state_e state_reg;
  uadc_state_e state_next;
  logic [GP_NUM-1:0] gpo_reg;
  logic [GP_NUM-1:0] gpoe_reg;

  // ****************************************************************
  // Address decode and pin selection
  // ****************************************************************
  wire logic hit_ctrl = (addr_in == OFF_CTRL);
  wire logic hit_pinsel = (addr_in == OFF_PINSEL);
  wire logic hit_power = (addr_in == OFF_POWER);
  wire logic hit_status = (addr_in == OFF_STATUS);
  wire logic [PIN_W-1:0] sense_pin = pinsel_reg[POS_SENSE +: PIN_W];
  wire logic [PIN_W-1:0] detach_pin = pinsel_reg[POS_DETACH +: PIN_W];
  wire logic [PIN_W-1:0] wake_pin = pinsel_reg[POS_WAKE +: PIN_W];
  wire logic [PIN_W-1:0] pull_pin = pinsel_reg[POS_PULL +: PIN_W];
  // Bus power and detach sensed on their chosen pins
  wire logic vbus = gp_in[sense_pin]; // [R08]
  wire logic detach = gp_in[detach_pin]; // [R18]
  wire logic pulled = (state_reg != ST_OFF);
  wire logic suspended = (state_reg == ST_SUSPENDED);
  wire logic int_pull = pulled & ~ctrl_reg.pullup_source_select; // [R06]
  wire logic ext_pull = pulled & ctrl_reg.pullup_source_select; // [R20]
  // Out-of-band wake replaces the cable message while detached
  wire logic host_wake = detach & ctrl_reg.wake_req; // [R16]

  // Status word read back by software
  wire logic [DATA_W-1:0] status_word = {24'h000000, 1'b0,
    suspended, pulled, detach, vbus, state_reg};

  // Read mux; unmapped addresses answer zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = {25'h0000000, ctrl_reg};
    end else if (hit_pinsel) begin
      rd_mux = {16'h0000, pinsel_reg};
    end else if (hit_power) begin
      rd_mux = {24'h000000, power_reg};
    end else if (hit_status) begin
      rd_mux = status_word;
    end else begin
      rd_mux = '0;
    end
  end

  // ****************************************************************
  // Connection state machine
  // ****************************************************************
  // Power loss or detach always wins, so D+ is never left pulled up
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (vbus && !detach && ctrl_reg.ready) begin
          state_next = ST_ATTACHED; // [R05] [R15]
        end
      end
      ST_ATTACHED: begin
        if (!vbus || detach || !ctrl_reg.ready) begin
          state_next = ST_OFF; // [R07] [R14]
        end else if (bus_suspend_in) begin
          state_next = ST_SUSPENDED; // [R11]
        end
      end
      ST_SUSPENDED: begin
        if (!vbus || detach || !ctrl_reg.ready) begin
          state_next = ST_OFF; // [R07] [R14]
        end else if (!bus_suspend_in) begin
          state_next = ST_ATTACHED;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Wake request drops once the link is up again; a write in that
  // same cycle still lands because the write is applied last
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reg <= RST_CTRL; // [R06]
    end else begin
      if (state_next == ST_ATTACHED && !detach) begin
        ctrl_reg.wake_req <= 1'b0;
      end
      if (wr_in && hit_ctrl) begin
        ctrl_reg <= wdata_in[CTRL_W-1:0];
      end
    end
  end

  // Pin selections and descriptor power setting
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pinsel_reg <= {RST_PULL_PIN, RST_WAKE_PIN, RST_DETACH_PIN,
        RST_SENSE_PIN};
      power_reg <= RST_POWER; // [R09]
    end else begin
      if (wr_in && hit_pinsel) begin
        pinsel_reg <= wdata_in[15:0]; // [R08] [R18]
      end
      if (wr_in && hit_power) begin
        power_reg <= wdata_in[PWR_W-1:0]; // [R10]
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_in ? rd_mux : '0;
    end
  end

  // ****************************************************************
  // General pin drivers
  // ****************************************************************
  // A pin chosen for both wake and pull-up is shared; a board must
  // not do that, the OR merely keeps it defined
  // The pull-up pin is released, never driven low, while D+ must
  // float: a low pin would load D+ through the external resistor
  generate
    for (genvar i = 0; i < GP_NUM; i++) begin : g_pin
      wire logic is_wake = (wake_pin == PIN_W'(i));
      wire logic is_pull = (pull_pin == PIN_W'(i));
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          gpo_reg[i] <= 1'b0;
          gpoe_reg[i] <= 1'b0;
        end else begin
          gpo_reg[i] <= (is_wake & host_wake) | (is_pull & ext_pull);
          gpoe_reg[i] <= is_wake | (is_pull & ext_pull); // [R14] [R20]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Peripheral only: this block asks the engine for nothing but an
  // in-band wake from suspend; full speed also on high-speed hosts
  assign full_speed_out = 1'b1; // [R01] [R19] [R02] [R03]
  assign dp_pullup_out = int_pull; // [R05]
  assign usb_hiz_out = detach | ~pulled; // [R14]
  assign inband_wake_out = suspended & ctrl_reg.wake_req
    & ~detach; // [R17]
  assign endpoint_set_out = ctrl_reg.endpoint_set; // [R04]
  assign desc_power_out = power_reg; // [R10]
  // Radio may not run in bus-powered suspend: 0.5 mA budget
  assign radio_en_out = ctrl_reg.radio_allow
    & ~(suspended & ctrl_reg.bus_powered); // [R12]
  assign aux_en_out = ctrl_reg.aux_allow & ~suspended; // [R13]
  assign rdata_out = rdata_reg;
  assign gp_out = gpo_reg;
  assign gp_oe_out = gpoe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  no_vbus_pull_a: assert property ( // [R07]
    !vbus |=> !dp_pullup_out && !ext_pull)
    else $error("D+ pulled without bus power");
  detach_float_a: assert property ( // [R14]
    detach |-> usb_hiz_out ##1 (!dp_pullup_out && !ext_pull))
    else $error("Lines not released on detach");
  reattach_a: assert property ( // [R15]
    (state_reg == ST_OFF && !detach && vbus && ctrl_reg.ready)
    |=> pulled)
    else $error("No reattach after detach release");
  ready_pull_a: assert property ( // [R05]
    (dp_pullup_out || ext_pull) |-> $past(ctrl_reg.ready))
    else $error("Pull-up before ready");
  ext_pin_a: assert property ( // [R20]
    (ext_pull && ctrl_reg.pullup_source_select) |=>
    gp_out[$past(pull_pin)] && gp_oe_out[$past(pull_pin)])
    else $error("External pull-up pin not driven");
  wake_when_det_a: assert property ( // [R16]
    host_wake |=> gp_out[$past(wake_pin)] && $past(detach))
    else $error("Host wake not driven while detached");
  inband_quiet_a: assert property ( // [R17]
    inband_wake_out |-> !detach && suspended)
    else $error("In-band wake while detached");
  radio_susp_a: assert property ( // [R12]
    (suspended && ctrl_reg.bus_powered) |-> !radio_en_out)
    else $error("Radio on in bus-powered suspend");
  aux_susp_a: assert property ( // [R13]
    suspended |-> !aux_en_out)
    else $error("LEDs or amplifiers on in suspend");
  suspend_in_a: assert property ( // [R11]
    (state_reg == ST_ATTACHED && bus_suspend_in && vbus && !detach
    && ctrl_reg.ready) |=> suspended)
    else $error("Suspend request not taken");
  rd_once_a: assert property (
    !rd_in |=> rdata_out == '0)
    else $error("Read data outside its cycle");
  power_reg_a: assert property ( // [R10]
    (wr_in && hit_power) |=> desc_power_out == $past(wdata_in[7:0]))
    else $error("Power setting not applied");
  power_hold_a: assert property ( // [R10]
    !(wr_in && hit_power) |=> $stable(desc_power_out))
    else $error("Power setting changed without a write");
  rd_power_a: assert property ( // [R10]
    (rd_in && hit_power) |=> rdata_out[PWR_W-1:0] == $past(power_reg))
    else $error("Power setting read back wrong");
  rd_status_a: assert property (
    (rd_in && hit_status) |=> rdata_out == $past(status_word))
    else $error("Status read back wrong");
  ctrl_wr_a: assert property ( // [R06]
    (wr_in && hit_ctrl) |=> ctrl_reg == $past(wdata_in[CTRL_W-1:0]))
    else $error("Control write not applied");
  pinsel_wr_a: assert property ( // [R18]
    (wr_in && hit_pinsel) |=> pinsel_reg == $past(wdata_in[15:0]))
    else $error("Pin selection write not applied");
  ep_wr_a: assert property ( // [R04]
    (wr_in && hit_ctrl) |=> endpoint_set_out == $past(wdata_in[3]))
    else $error("Endpoint set not applied");

  // ****************************************************************
  // Checks on the connection state
  // ****************************************************************
  // One-hot state keeps the status word unambiguous for software
  state_onehot_a: assert property (
    $onehot(state_reg))
    else $error("Connection state not one-hot");
  resume_a: assert property ( // [R11]
    (suspended && !bus_suspend_in && vbus && !detach && ctrl_reg.ready)
    |=> state_reg == ST_ATTACHED)
    else $error("No return from suspend");
  susp_drop_a: assert property ( // [R07] [R14]
    (suspended && (!vbus || detach)) |=> state_reg == ST_OFF)
    else $error("Suspend kept after power loss or detach");
  off_hold_a: assert property ( // [R05]
    (state_reg == ST_OFF && !ctrl_reg.ready) |=> state_reg == ST_OFF)
    else $error("Attach before firmware ready");
  sense_off_a: assert property ( // [R08]
    (state_reg == ST_OFF && !gp_in[sense_pin]) |=> state_reg == ST_OFF)
    else $error("Attach without power on the sense pin");
  off_float_a: assert property ( // [R14]
    !pulled |-> usb_hiz_out && !dp_pullup_out)
    else $error("Lines driven while not attached");
  attach_drive_a: assert property ( // [R15]
    (pulled && !detach) |-> !usb_hiz_out)
    else $error("Lines floating while attached");
  detach_pin_a: assert property ( // [R18]
    gp_in[detach_pin] |-> usb_hiz_out)
    else $error("Chosen detach pin ignored");
  int_select_a: assert property ( // [R06]
    dp_pullup_out |-> !ctrl_reg.pullup_source_select)
    else $error("Internal pull-up on in external mode");
  int_follow_a: assert property ( // [R06]
    (pulled && !ctrl_reg.pullup_source_select) |-> dp_pullup_out)
    else $error("Internal pull-up missing while attached");
  fs_only_a: assert property ( // [R01] [R19]
    full_speed_out)
    else $error("Full speed not advertised");
  // The radio may only be held off by bus-powered suspend, the aux loads by any suspend
  radio_free_a: assert property ( // [R12]
    (ctrl_reg.radio_allow && !(suspended && ctrl_reg.bus_powered))
    |-> radio_en_out)
    else $error("Radio held off outside bus-powered suspend");
  aux_free_a: assert property ( // [R13]
    (ctrl_reg.aux_allow && !suspended) |-> aux_en_out)
    else $error("LEDs or amplifiers held off while awake");
  inband_susp_a: assert property ( // [R17]
    (suspended && ctrl_reg.wake_req && !detach) |-> inband_wake_out)
    else $error("In-band wake missing in suspend");
  inband_req_a: assert property ( // [R02]
    inband_wake_out |-> ctrl_reg.wake_req)
    else $error("In-band wake without a request");
  // A stale wake request would otherwise fire at the next suspend
  wake_clear_a: assert property ( // [R16]
    (state_next == ST_ATTACHED && !(wr_in && hit_ctrl))
    |=> !ctrl_reg.wake_req)
    else $error("Wake request kept after reattach");

  // ****************************************************************
  // Checks on the general pins
  // ****************************************************************
  // A pin shared by wake and pull-up is no legal board, so those
  // checks leave it out
  ext_release_a: assert property ( // [R20]
    (!ext_pull && pull_pin != wake_pin) |=>
    !gp_out[$past(pull_pin)] && !gp_oe_out[$past(pull_pin)])
    else $error("External pull-up pin not released");
  ext_float_a: assert property ( // [R14]
    (detach && $past(detach) && pull_pin != wake_pin) |=>
    !gp_oe_out[$past(pull_pin)])
    else $error("Pull-up pin driven while detached");
  ext_unused_a: assert property ( // [R06]
    (!ctrl_reg.pullup_source_select && pull_pin != wake_pin) |=>
    !gp_oe_out[$past(pull_pin)])
    else $error("Pull-up pin driven in internal mode");
  wake_idle_a: assert property ( // [R16]
    (!detach && wake_pin != pull_pin) |=> !gp_out[$past(wake_pin)])
    else $error("Host wake raised while attached");
  wake_drive_a: assert property ( // [R18]
    host_wake |=> gp_oe_out[$past(wake_pin)])
    else $error("Host wake pin not driven");

endmodule

// file: bench/uadc_host_model.sv
/* Host or hub model at the far end of the cable.
   Assumes the device pins are levels on clk_in. */
`timescale 1ns/1ps
module uadc_host_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic power_in,
  input wire logic suspend_req_in,
  input wire logic pulled_in,
  input wire logic hiz_in,
  input wire logic full_speed_in,
  output logic vbus_out,
  output logic bus_suspend_out
);
  // ****************************************
  // Host side
  // ****************************************
  logic seen;
  // Cable power is the host's to give
  assign vbus_out = power_in;
  // Only a pulled, driven full-speed D+ is seen
  assign seen = pulled_in & ~hiz_in & full_speed_in & power_in;
  // Suspends only a seen device, one edge late like a hub
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_suspend_out <= 1'b0;
    end else begin
      bus_suspend_out <= suspend_req_in & seen;
    end
  end
endmodule

// file: bench/uadc_attach_ctrl_tb.sv
/* Testbench for the attach and detach block.
   Assumes the host model drives cable power and suspend. */
`timescale 1ns/1ps
module usb_attach_detach_control_tb;
  import uadc_pkg::*;
  logic clk_in, arst_n_in, wr, rd, fs, pup, hiz, inb, ep;
  logic radio, aux, power, susreq, vbus, sus;
  logic [7:0] addr, pwr;
  logic [31:0] wdata, rdata;
  logic [15:0] gp_in, gp_out, gp_oe, pins;
  logic [3:0] sidx, pidx;
  int fail_count = 0;
  int num_checks = 0;
  // Sense pin carries cable power; other pins come from the board
  assign gp_in = pins | (16'(vbus) << sidx);
  uadc_attach_ctrl dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .gp_in(gp_in), .gp_out(gp_out),
    .gp_oe_out(gp_oe), .bus_suspend_in(sus), .dp_pullup_out(pup),
    .usb_hiz_out(hiz), .full_speed_out(fs), .inband_wake_out(inb),
    .endpoint_set_out(ep), .desc_power_out(pwr),
    .radio_en_out(radio), .aux_en_out(aux));
  uadc_host_model host (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .power_in(power), .suspend_req_in(susreq),
    .pulled_in(pup | (gp_out[pidx] & gp_oe[pidx])), .hiz_in(hiz),
    .full_speed_in(fs), .vbus_out(vbus), .bus_suspend_out(sus));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    {arst_n_in, wr, rd, power, susreq} = 5'h00;
    addr = 8'h00;
    wdata = 32'h0;
    pins = 16'h0;
    sidx = 4'h0;
    pidx = 4'h3;
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rdc(OFF_CTRL, 32'hffffffff, 32'h34);
    rdc(OFF_PINSEL, 32'hffffffff, 32'h3210);
    rdc(OFF_POWER, 32'hffffffff, 32'h32);
    rdc(8'h10, 32'hffffffff, 32'h0);
    chk(fs, 1'b1);
    chk(pup, 1'b0);
    chk(pwr, 8'h32);
    $display("test reset done");
    power <= 1'b1;
    step(3);
    chk(pup, 1'b0);
    wrr(OFF_CTRL, 32'h35);
    step(2);
    chk({pup, hiz}, 2'b10);
    rdc(OFF_STATUS, 32'h7, 32'h2);
    $display("test attach done");
    susreq <= 1'b1;
    step(3);
    chk({radio, aux}, 2'b00);
    rdc(OFF_STATUS, 32'h7, 32'h4);
    // Self-powered suspend keeps the radio, drops LEDs, wakes in band
    wrr(OFF_CTRL, 32'h71);
    step(1);
    chk({radio, aux, inb}, 3'b101);
    susreq <= 1'b0;
    step(3);
    rdc(OFF_STATUS, 32'h7, 32'h2);
    rdc(OFF_CTRL, 32'h40, 32'h0);
    chk(aux, 1'b1);
    $display("test suspend done");
    @(posedge clk_in);
    pins <= 16'h0002;
    #1 chk(hiz, 1'b1);
    step(2);
    chk(pup, 1'b0);
    wrr(OFF_CTRL, 32'h71);
    step(2);
    chk({gp_oe[2], gp_out[2], inb}, 3'b110);
    pins <= 16'h0;
    step(3);
    chk({pup, gp_out[2]}, 2'b10);
    $display("test detach done");
    // Move every pin; power on pin 5, pull-up on pin 8
    wrr(OFF_PINSEL, 32'h8765);
    sidx <= 4'h5;
    pidx <= 4'h8;
    wrr(OFF_CTRL, 32'h37);
    step(3);
    chk({pup, gp_oe[8], gp_out[8]}, 3'b011);
    pins <= 16'h0040;
    step(3);
    chk({hiz, gp_oe[8], gp_out[8]}, 3'b100);
    pins <= 16'h0;
    step(3);
    chk(gp_out[8], 1'b1);
    power <= 1'b0;
    step(3);
    chk({gp_oe[8], gp_out[8]}, 2'b00);
    rdc(OFF_STATUS, 32'h7, 32'h1);
    $display("test pins done");
    wrr(OFF_POWER, 32'h164);
    step(1);
    chk(pwr, 8'h64);
    rdc(OFF_POWER, 32'hffffffff, 32'h64);
    wrr(OFF_CTRL, 32'h08);
    step(1);
    chk(ep, 1'b1);
    wrr(OFF_CTRL, 32'h00);
    step(1);
    chk(ep, 1'b0);
    $display("test settings done");
    // Reset in mid-run restores the defaults
    arst_n_in <= 1'b0;
    step(2);
    chk({pup, hiz, gp_oe[8]}, 3'b010);
    arst_n_in <= 1'b1;
    rdc(OFF_CTRL, 32'hffffffff, 32'h34);
    rdc(OFF_PINSEL, 32'hffffffff, 32'h3210);
    chk(pwr, 8'h32);
    $display("test reset again done");
    summarize();
  end
endmodule
